// [dcw_pkg.sv]
// Purpose: Shared constants and types for the descriptor control word logic
// Assumes: One device clock, 16-bit control words on a plain register port
// Notes: Offsets are word addresses on the register port
package dcw_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] DCW_ADDR_SA_CTRL = 4'h0;
    localparam logic [3:0] DCW_ADDR_RX_MODE = 4'h1;
    localparam logic [3:0] DCW_ADDR_CONFIG = 4'h2;
    localparam logic [3:0] DCW_ADDR_STATUS = 4'h3;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int DCW_B_CIR1 = 0;
    localparam int DCW_B_CIR2 = 1;
    localparam int DCW_B_PINGPONG_ENABLE = 2;
    localparam int DCW_B_STOP = 3;
    localparam int DCW_B_PPACK = 8;
    localparam int DCW_B_BROADCAST_RECEIVED_FLAG = 9;
    localparam int DCW_B_NBUF = 10;
    localparam int DCW_B_ACC = 11;
    localparam int DCW_B_SMP = 0;
    localparam int DCW_B_EXEC = 1;
    // Host write masks for the mode command word
    localparam logic [15:0] DCW_RXM_ANYTIME = 16'hF008;
    localparam logic [15:0] DCW_RXM_IDLE_ONLY = 16'h0004;
    localparam logic [15:0] DCW_RXM_DEV_BITS = 16'h0F00;
    // Bits the simplified mode keeps active in the mode command word
    localparam logic [15:0] DCW_RXM_SMP_MASK = 16'hFB08;
    localparam logic [15:0] DCW_RESET_WORD = 16'h0000;
    localparam logic [4:0] DCW_SA_MODE_LO = 5'h00;
    localparam logic [4:0] DCW_SA_MODE_HI = 5'h1F;
    // Descriptor block size and data-bearing mode codes
    localparam logic [2:0] DCW_BLOCK_WORDS = 3'h4;
    localparam logic [4:0] DCW_MC_DATA_LO = 5'h10;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DCW_MODE_INDEX = 2'b00,
        DCW_MODE_CIRC1 = 2'b01,
        DCW_MODE_CIRC2 = 2'b10,
        DCW_MODE_PPONG = 2'b11
    } dcw_mode_t;
    typedef enum logic [1:0] {
        DCW_PP_IDLE = 2'b00,
        DCW_PP_ON = 2'b01,
        DCW_PP_OFF = 2'b10
    } dcw_pp_t;
    // Message from the terminal engine
    typedef struct packed {
        logic start;     // Command accepted, message begins
        logic done;      // Message finished
        logic good;      // Finished without error, illegal or busy
        logic tx;        // Transmit/receive bit of the command
        logic broadcast_received_flag;     // Broadcast command
        logic [4:0] sa;  // Subaddress field
        logic [4:0] mc;  // Mode code field
    } dcw_msg_t;
    // Buffer decision sent to the terminal engine
    typedef struct packed {
        dcw_mode_t mode;     // Buffer scheme in force
        logic use_b;         // Use data pointer B
        logic in_block;      // Store words inside descriptor block
        logic follow_ptr;    // Follow data pointers
        logic [2:0] nwords;  // Words stored in the block
    } dcw_buf_t;
endpackage

// [dcw_mode_sel.sv]
// Purpose: Decode the three buffer select bits into a buffer scheme
// Assumes: Mode commands cannot use circular schemes
// Notes: Purely combinational
`timescale 1ns/1ps
module dcw_mode_sel
    import dcw_pkg::*;
(
    input wire logic [2:0] sel_bits,   // Ping-pong, circ2, circ1 bits
    input wire logic is_mode,          // Word belongs to a mode command
    input wire logic smp,              // Simplified mode processing on
    output dcw_mode_t mode             // Decoded scheme
);
    // Priority decode of the select bits
    always_comb begin
        mode = DCW_MODE_INDEX;
        if (is_mode) begin
            if (!smp && sel_bits[2]) begin
                mode = DCW_MODE_PPONG;
            end
        end else if (sel_bits[2]) begin
            mode = DCW_MODE_PPONG;
        end else if (sel_bits[1]) begin
            mode = DCW_MODE_CIRC2;
        end else if (sel_bits[0]) begin
            mode = DCW_MODE_CIRC1;
        end
    end
endmodule

// [dcw_pingpong.sv]
// Purpose: Ping-pong suspend and resume handshake and buffer toggle
// Assumes: Engine marks message start and done with one-cycle pulses
// Notes: Stop request is sampled only between messages
`timescale 1ns/1ps
module dcw_pingpong
    import dcw_pkg::*;
(
    input wire logic clock,       // Device clock
    input wire logic rst,         // Master reset
    input wire logic soft_rst,    // Software reset pulse
    input wire logic enable,      // Ping-pong selected for this word
    input wire logic stop_req,    // Host stop request bit
    input wire logic msg_start,   // Message for this word starts
    input wire logic msg_done,    // Message for this word ends
    input wire logic msg_good,    // Message ended without fault
    output logic ack_ff,          // Ping-pong active acknowledge
    output logic nbuf_ff          // Next buffer select
);
    dcw_pp_t state_ff;
    logic busy_ff;
    // Track a message in progress
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_ff <= 1'b0;
        end else if (msg_start) begin
            busy_ff <= 1'b1;
        end else if (msg_done) begin
            busy_ff <= 1'b0;
        end
    end
    // Handshake state, changes only while no message runs
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= DCW_PP_IDLE;
            ack_ff <= 1'b0;
        end else if (!busy_ff && !msg_start) begin
            unique case (state_ff)
                DCW_PP_IDLE: begin
                    if (enable) begin
                        state_ff <= stop_req ? DCW_PP_OFF : DCW_PP_ON;
                        ack_ff <= !stop_req;
                    end
                end
                DCW_PP_ON: begin
                    if (!enable || stop_req) begin
                        state_ff <= enable ? DCW_PP_OFF : DCW_PP_IDLE;
                        ack_ff <= 1'b0;
                    end
                end
                DCW_PP_OFF: begin
                    if (!enable) begin
                        state_ff <= DCW_PP_IDLE;
                    end else if (!stop_req) begin
                        state_ff <= DCW_PP_ON;
                        ack_ff <= 1'b1;
                    end
                end
                default: begin
                    state_ff <= DCW_PP_IDLE;
                    ack_ff <= 1'b0;
                end
            endcase
        end
    end
    // Toggle buffer after good messages while active
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            nbuf_ff <= 1'b0;
        end else if (soft_rst) begin
            nbuf_ff <= 1'b0;
        end else if (msg_done && msg_good && enable && ack_ff) begin
            nbuf_ff <= !nbuf_ff;
        end
    end
endmodule

// [dcw_top.sv]
// Purpose: Descriptor control word logic for a serial-bus remote terminal
// Assumes: Host port synchronous to clock, read data one cycle later
// Notes: One subaddress word and one receive mode command word
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module dcw_top
    import dcw_pkg::*;
(
    input wire logic clock,              // Device clock, 25 MHz
    input wire logic rst,                // Master reset, async high
    input wire logic [3:0] reg_addr,     // Register word address
    input wire logic [15:0] reg_wdata,   // Write data
    input wire logic reg_wr,             // Write strobe
    input wire logic reg_rd,             // Read strobe
    output logic [15:0] reg_rdata_ff,    // Read data, cycle after strobe
    input wire dcw_msg_t msg,            // Message events from engine
    output dcw_buf_t sa_buf_ff,          // Subaddress buffer decision
    output dcw_buf_t mc_buf_ff           // Mode command buffer decision
);
    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [15:0] sa_word_ff;
    logic [15:0] rxm_word_ff;
    logic [1:0] cfg_ff;
    logic soft_rst;
    logic smp;
    logic exec_on;
    logic wr_sa;
    logic wr_rxm;
    logic wr_cfg;
    logic rd_rxm;
    logic sa_hit;
    logic mc_hit;
    logic sa_ack;
    logic sa_nbuf;
    logic mc_ack;
    logic mc_nbuf;
    logic mc_acc_set;
    logic mc_bc_set;
    logic [15:0] nxt_rxm;
    logic [15:0] nxt_sa;
    dcw_mode_t sa_mode;
    dcw_mode_t mc_mode;
    // Strobe decode
    assign wr_sa = reg_wr && (reg_addr == DCW_ADDR_SA_CTRL);
    assign wr_rxm = reg_wr && (reg_addr == DCW_ADDR_RX_MODE);
    assign wr_cfg = reg_wr && (reg_addr == DCW_ADDR_CONFIG);
    assign rd_rxm = reg_rd && (reg_addr == DCW_ADDR_RX_MODE);
    assign soft_rst = reg_wr && (reg_addr == DCW_ADDR_STATUS) && reg_wdata[0];
    assign smp = cfg_ff[DCW_B_SMP];
    assign exec_on = cfg_ff[DCW_B_EXEC];
    // Message routing: receive mode commands to the mode word, non-mode subaddresses to the subaddress word
    assign mc_hit = !msg.tx && ((msg.sa == DCW_SA_MODE_LO) || (msg.sa == DCW_SA_MODE_HI));
    assign sa_hit = (msg.sa != DCW_SA_MODE_LO) && (msg.sa != DCW_SA_MODE_HI);
    assign mc_acc_set = exec_on && mc_hit && msg.done;
    assign mc_bc_set = mc_acc_set && msg.broadcast_received_flag;
    // ----------------------------------------------------------------
    // Configuration: simplified mode and execution enable
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cfg_ff <= 2'b00;
        end else if (wr_cfg) begin
            cfg_ff <= reg_wdata[1:0];
        end
    end
    // ----------------------------------------------------------------
    // Mode decode and ping-pong engines
    // ----------------------------------------------------------------
    dcw_mode_sel u_sa_sel (
        .sel_bits(sa_word_ff[2:0]),
        .is_mode(1'b0),
        .smp(smp),
        .mode(sa_mode)
    );
    dcw_mode_sel u_mc_sel (
        .sel_bits(rxm_word_ff[2:0]),
        .is_mode(1'b1),
        .smp(smp),
        .mode(mc_mode)
    );
    dcw_pingpong u_sa_pp (
        .clock(clock),
        .rst(rst),
        .soft_rst(soft_rst),
        .enable(sa_mode == DCW_MODE_PPONG),
        .stop_req(sa_word_ff[DCW_B_STOP]),
        .msg_start(msg.start && sa_hit),
        .msg_done(msg.done && sa_hit),
        .msg_good(msg.good),
        .ack_ff(sa_ack),
        .nbuf_ff(sa_nbuf)
    );
    dcw_pingpong u_mc_pp (
        .clock(clock),
        .rst(rst),
        .soft_rst(soft_rst),
        .enable(mc_mode == DCW_MODE_PPONG && exec_on),
        .stop_req(rxm_word_ff[DCW_B_STOP]),
        .msg_start(msg.start && mc_hit),
        .msg_done(msg.done && mc_hit),
        .msg_good(msg.good),
        .ack_ff(mc_ack),
        .nbuf_ff(mc_nbuf)
    );
    // ----------------------------------------------------------------
    // Subaddress control word
    // ----------------------------------------------------------------
    always_comb begin
        nxt_sa = sa_word_ff;
        if (wr_sa) begin
            nxt_sa = reg_wdata & ~DCW_RXM_DEV_BITS;
            nxt_sa[DCW_B_BROADCAST_RECEIVED_FLAG] = sa_word_ff[DCW_B_BROADCAST_RECEIVED_FLAG];
        end
        if (soft_rst) begin
            nxt_sa[DCW_B_BROADCAST_RECEIVED_FLAG] = 1'b0;
        end
        if (msg.done && sa_hit && msg.tx && msg.broadcast_received_flag) begin
            nxt_sa[DCW_B_BROADCAST_RECEIVED_FLAG] = 1'b1;
        end
        nxt_sa[DCW_B_PPACK] = sa_ack;
        nxt_sa[DCW_B_NBUF] = sa_nbuf;
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sa_word_ff <= DCW_RESET_WORD;
        end else begin
            sa_word_ff <= nxt_sa;
        end
    end
    // ----------------------------------------------------------------
    // Receive mode command control word
    // ----------------------------------------------------------------
    always_comb begin
        nxt_rxm = rxm_word_ff;
        if (wr_rxm) begin
            nxt_rxm = (rxm_word_ff & ~DCW_RXM_ANYTIME) | (reg_wdata & DCW_RXM_ANYTIME);
            if (!exec_on) begin
                nxt_rxm[DCW_B_PINGPONG_ENABLE] = reg_wdata[DCW_B_PINGPONG_ENABLE];
                nxt_rxm[1:0] = reg_wdata[1:0];
                nxt_rxm[7:4] = reg_wdata[7:4];
            end
        end
        if (soft_rst) begin
            nxt_rxm[DCW_B_ACC] = 1'b0;
            nxt_rxm[DCW_B_BROADCAST_RECEIVED_FLAG] = 1'b0;
        end
        if (rd_rxm) begin
            nxt_rxm[DCW_B_ACC] = 1'b0;
        end
        if (mc_acc_set) begin
            nxt_rxm[DCW_B_ACC] = 1'b1;
        end
        if (mc_bc_set) begin
            nxt_rxm[DCW_B_BROADCAST_RECEIVED_FLAG] = 1'b1;
        end
        if (exec_on) begin
            nxt_rxm[DCW_B_PPACK] = mc_ack && !smp;
            nxt_rxm[DCW_B_NBUF] = mc_nbuf && !smp;
        end else if (soft_rst) begin
            nxt_rxm[DCW_B_NBUF] = 1'b0;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rxm_word_ff <= DCW_RESET_WORD;
        end else begin
            rxm_word_ff <= nxt_rxm;
        end
    end
    // ----------------------------------------------------------------
    // Buffer decisions for the terminal engine
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sa_buf_ff <= '0;
            mc_buf_ff <= '0;
        end else begin
            sa_buf_ff.mode <= sa_mode;
            sa_buf_ff.use_b <= sa_nbuf && (sa_mode == DCW_MODE_PPONG);
            sa_buf_ff.in_block <= 1'b0;
            sa_buf_ff.follow_ptr <= 1'b1;
            sa_buf_ff.nwords <= 3'h0;
            mc_buf_ff.mode <= mc_mode;
            mc_buf_ff.use_b <= mc_nbuf && (mc_mode == DCW_MODE_PPONG);
            mc_buf_ff.in_block <= smp;
            mc_buf_ff.follow_ptr <= !smp;
            mc_buf_ff.nwords <= (smp && msg.mc >= DCW_MC_DATA_LO) ? DCW_BLOCK_WORDS : 3'h0;
        end
    end
    // ----------------------------------------------------------------
    // Read port, data stands in the cycle after the strobe
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= 16'h0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                DCW_ADDR_SA_CTRL: reg_rdata_ff <= sa_word_ff;
                DCW_ADDR_RX_MODE: reg_rdata_ff <= smp ? (rxm_word_ff & DCW_RXM_SMP_MASK)
                                                      : rxm_word_ff;
                DCW_ADDR_CONFIG: reg_rdata_ff <= {14'h0000, cfg_ff};
                default: reg_rdata_ff <= 16'h0000;
            endcase
        end else begin
            reg_rdata_ff <= 16'h0000;
        end
    end
endmodule

// [dcw_top_properties.sv]
// Purpose: Concurrent checks on the control word block ports
// Assumes: One clock domain, master reset async high
// Notes: Bound to every dcw_top instance
`timescale 1ns/1ps
module dcw_top_properties
    import dcw_pkg::*;
(
    input wire logic clock,            // Device clock
    input wire logic rst,              // Master reset
    input wire logic [3:0] reg_addr,   // Register address
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic reg_wr,           // Write strobe
    input wire logic reg_rd,           // Read strobe
    input wire logic [15:0] reg_rdata_ff, // Read data
    input wire dcw_msg_t msg,          // Engine events
    input wire dcw_buf_t sa_buf_ff,    // Subaddress decision
    input wire dcw_buf_t mc_buf_ff     // Mode command decision
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ----------------------------------------------------------------
    // Host writes that pick a buffer scheme
    // ----------------------------------------------------------------
    sequence s_sa_pp_wr;
        reg_wr && reg_addr == DCW_ADDR_SA_CTRL && reg_wdata[DCW_B_PINGPONG_ENABLE];
    endsequence
    sequence s_sa_idx_wr;
        reg_wr && reg_addr == DCW_ADDR_SA_CTRL && reg_wdata[2:0] == 3'h0;
    endsequence
    chk_sa_mode_pp: assert property (s_sa_pp_wr |-> ##[1:3] sa_buf_ff.mode == DCW_MODE_PPONG)
        else $error("subaddress scheme not ping-pong after enable write");
    chk_sa_mode_idx: assert property (s_sa_idx_wr |-> ##[1:3] sa_buf_ff.mode == DCW_MODE_INDEX)
        else $error("subaddress scheme not indexed after clear write");
    chk_read_idle: assert property (!reg_rd |=> reg_rdata_ff == 16'h0000)
        else $error("read data present without a read strobe");
    chk_unmapped_read: assert property (reg_rd && reg_addr > DCW_ADDR_STATUS |=> reg_rdata_ff == 16'h0000)
        else $error("unmapped address returned data");
    chk_mc_no_circ: assert property (mc_buf_ff.mode inside {DCW_MODE_INDEX, DCW_MODE_PPONG})
        else $error("mode command given a circular scheme");
    // Skip the first edge after reset, the decision register still holds its reset value there
    chk_sa_ptr_fixed: assert property (!$past(rst) |-> !sa_buf_ff.in_block && sa_buf_ff.follow_ptr)
        else $error("subaddress decision stores in block");
    chk_mc_no_ptr: assert property (mc_buf_ff.in_block |-> !mc_buf_ff.follow_ptr)
        else $error("pointers followed while storing in block");
    chk_mc_smp_index: assert property ($rose(mc_buf_ff.in_block) |-> ##[0:3]
        mc_buf_ff.mode == DCW_MODE_INDEX)
        else $error("simplified mode kept ping-pong scheme");
    chk_block_words: assert property (mc_buf_ff.nwords == 3'h0 ||
        (mc_buf_ff.nwords == DCW_BLOCK_WORDS && mc_buf_ff.in_block))
        else $error("block word count wrong");
endmodule
bind dcw_top dcw_top_properties i_dcw_top_properties (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .msg(msg), .sa_buf_ff(sa_buf_ff), .mc_buf_ff(mc_buf_ff));

// [dcw_engine_model.sv]
// Purpose: Terminal engine stand-in that issues message start and done
// Assumes: One request at a time, start then done after a gap
// Notes: Fields float to inverted values between events
`timescale 1ns/1ps
module dcw_engine_model
    import dcw_pkg::*;
#(
    parameter int GAP = 4
)
(
    input wire logic clock,       // Device clock
    input wire logic rst,         // Master reset
    input wire logic req,         // Send one message
    input wire dcw_msg_t req_msg, // Fields of the message
    output dcw_msg_t msg,         // Events to the block
    output logic busy             // Message in flight
);
    logic [3:0] cnt_ff;
    dcw_msg_t hold_ff;
    // Count from start down to done
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_ff <= 4'h0;
            hold_ff <= '0;
        end else if (req && cnt_ff == 4'h0) begin
            cnt_ff <= 4'(GAP);
            hold_ff <= req_msg;
        end else if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end
    // Start then done, never both; good only with done
    always_comb begin
        msg = ~hold_ff;
        msg.start = 1'b0;
        msg.done = 1'b0;
        msg.good = 1'b0;
        if (cnt_ff == 4'(GAP)) begin
            msg = hold_ff;
            msg.start = 1'b1;
            msg.done = 1'b0;
            msg.good = 1'b0;
        end
        if (cnt_ff == 4'h1) begin
            msg = hold_ff;
            msg.start = 1'b0;
            msg.done = 1'b1;
        end
    end
    assign busy = cnt_ff != 4'h0;
endmodule

// [testbench.sv]
// Purpose: Self-checking bench for the control word block
// Assumes: Host tasks keep the one-cycle strobe bus
// Notes: Expected words are worked out by hand per scenario
`timescale 1ns/1ps
module testbench;
    import dcw_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata_ff;
    logic req = 1'b0;
    logic busy;
    dcw_msg_t req_msg = '0;
    dcw_msg_t msg;
    dcw_buf_t sa_buf_ff;
    dcw_buf_t mc_buf_ff;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    dcw_top i_dcw_top (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .msg(msg),
        .sa_buf_ff(sa_buf_ff), .mc_buf_ff(mc_buf_ff));
    dcw_engine_model i_dcw_engine_model (.clock(clock), .rst(rst), .req(req),
        .req_msg(req_msg), .msg(msg), .busy(busy));
    // ----------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------------------------------
    initial begin
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 check(n, reg_rdata_ff, e);
    endtask
    task automatic send(input logic tx, input logic [4:0] sa, input logic ok, input logic bc);
        int n = 0;
        @(posedge clock);
        req_msg <= '{start: 1'b0, done: 1'b0, good: ok, tx: tx, broadcast_received_flag: bc, sa: sa, mc: 5'h11};
        req <= 1'b1;
        @(posedge clock);
        req <= 1'b0;
        #1;
        while (busy !== 1'b0 && n < 50) begin
            @(posedge clock);
            n++;
        end
        repeat (4) @(posedge clock);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(DCW_ADDR_RX_MODE, 16'h0000, "rx word after reset");
        rd(DCW_ADDR_SA_CTRL, 16'h0000, "sa word after reset");
        rd(4'hF, 16'h0000, "unmapped read");
        $display("test reset done");
    endtask
    task automatic t_modes();
        logic [1:0] e;
        for (int i = 0; i < 8; i++) begin
            wr(DCW_ADDR_SA_CTRL, 16'(i));
            e = i[2] ? 2'b11 : (i[1] ? 2'b10 : (i[0] ? 2'b01 : 2'b00));
            check("sa scheme", {14'h0, sa_buf_ff.mode}, {14'h0, e});
        end
        $display("test modes done");
    endtask
    task automatic t_sa_pingpong();
        wr(DCW_ADDR_SA_CTRL, 16'h0004);
        rd(DCW_ADDR_SA_CTRL, 16'h0104, "ack on enable");
        send(1'b1, 5'h01, 1'b1, 1'b0);
        rd(DCW_ADDR_SA_CTRL, 16'h0504, "toggle after good");
        check("sa use b", {15'h0, sa_buf_ff.use_b}, 16'h0001);
        send(1'b1, 5'h01, 1'b0, 1'b0);
        rd(DCW_ADDR_SA_CTRL, 16'h0504, "no toggle after fault");
        wr(DCW_ADDR_SA_CTRL, 16'h000C);
        rd(DCW_ADDR_SA_CTRL, 16'h040C, "ack clear on stop");
        send(1'b1, 5'h01, 1'b1, 1'b0);
        rd(DCW_ADDR_SA_CTRL, 16'h040C, "stopped keeps buffer");
        wr(DCW_ADDR_SA_CTRL, 16'h0004);
        rd(DCW_ADDR_SA_CTRL, 16'h0504, "ack back on resume");
        $display("test sa pingpong done");
    endtask
    task automatic t_rx_word();
        wr(DCW_ADDR_RX_MODE, 16'hFFFF);
        rd(DCW_ADDR_RX_MODE, 16'hF0FF, "idle host write");
        wr(DCW_ADDR_RX_MODE, 16'h0004);
        wr(DCW_ADDR_CONFIG, 16'h0002);
        check("mc scheme", {14'h0, mc_buf_ff.mode}, {14'h0, DCW_MODE_PPONG});
        wr(DCW_ADDR_RX_MODE, 16'hF0F0);
        rd(DCW_ADDR_RX_MODE, 16'hF104, "running host write");
        send(1'b1, DCW_SA_MODE_HI, 1'b1, 1'b0);
        rd(DCW_ADDR_RX_MODE, 16'hF104, "transmit leaves rx word");
        send(1'b0, DCW_SA_MODE_LO, 1'b1, 1'b1);
        rd(DCW_ADDR_RX_MODE, 16'hFF04, "status after message");
        rd(DCW_ADDR_RX_MODE, 16'hF704, "accessed cleared by read");
        send(1'b0, DCW_SA_MODE_HI, 1'b1, 1'b1);
        wr(DCW_ADDR_STATUS, 16'h0001);
        rd(DCW_ADDR_RX_MODE, 16'hF104, "soft reset bits");
        rd(DCW_ADDR_SA_CTRL, 16'h0104, "sa soft reset bits");
        $display("test rx word done");
    endtask
    task automatic t_simplified();
        wr(DCW_ADDR_CONFIG, 16'h0003);
        check("smp scheme", {14'h0, mc_buf_ff.mode}, {14'h0, DCW_MODE_INDEX});
        check("in block", {15'h0, mc_buf_ff.in_block}, 16'h0001);
        check("follow ptr", {15'h0, mc_buf_ff.follow_ptr}, 16'h0000);
        rd(DCW_ADDR_RX_MODE, 16'hF000, "reduced bits");
        send(1'b0, DCW_SA_MODE_LO, 1'b1, 1'b0);
        rd(DCW_ADDR_RX_MODE, 16'hF800, "accessed under simplified");
        $display("test simplified done");
    endtask
    task automatic t_master_reset();
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(DCW_ADDR_RX_MODE, 16'h0000, "rx word after master reset");
        $display("test master reset done");
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_modes();
        t_sa_pingpong();
        t_rx_word();
        t_simplified();
        t_master_reset();
        end_sim();
    end
endmodule
